// file: logic/expander_port_pkg.sv
// shared constants and carrier types for the expander port and interrupt logic
package expander_port_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_INTERRUPT_FLAG = 8'h07;
	localparam logic [7:0] ADDR_INTERRUPT_CAPTURE = 8'h08;
	localparam logic [7:0] ADDR_PORT_PIN_LEVELS = 8'h09;
	localparam logic [7:0] ADDR_OUTPUT_LATCH = 8'h0A;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INTERRUPT_FLAG = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_CAPTURE = 8'h00;
	localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
	localparam logic [7:0] RST_READ_DATA = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_DATA = 8'h00;

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	// one register access from the serial engine, rd and wr are one-cycle pulses
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	// per-pin configuration held by the neighbouring register set
	typedef struct packed {
		logic [7:0] dir_input;
		logic [7:0] pin_irq_enable;
		logic [7:0] compare_value;
		logic [7:0] compare_mode_select;
	} pin_cfg_type;

	// interrupt pin configuration bits of device_config
	typedef struct packed {
		logic open_drain_select;
		logic irq_polarity;
	} irq_cfg_type;

endpackage

// file: logic/pin_level_sync.sv
// three-stage synchroniser with agreement filter for the port pins
`timescale 1ns/1ps
`default_nettype none

module pin_level_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pins_i,
	output logic [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	logic [WIDTH-1:0] level_next;

	// a bit changes only once stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
		end
	end

	// shift chain, first stage feeds only the second
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			level_reg <= '0;
		end else begin
			s1_reg <= pins_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level_o = level_reg;

endmodule

`default_nettype wire

// file: logic/irq_pin_driver.sv
// interrupt pin driver: push-pull with polarity, or open-drain
`timescale 1ns/1ps
`default_nettype none

module irq_pin_driver (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic active_i,
	input wire expander_port_pkg::irq_cfg_type cfg_i,
	output logic irq_out_o,
	output logic irq_oe_n_o
);

	logic out_reg;
	logic out_next;
	logic oe_n_reg;
	logic oe_n_next;

	// open-drain pulls low when active and ignores polarity
	always_comb begin
		if (cfg_i.open_drain_select) begin
			out_next = 1'b0;
			oe_n_next = ~active_i;
		end else begin
			out_next = cfg_i.irq_polarity ? active_i : ~active_i;
			oe_n_next = 1'b0;
		end
	end

	// pin released during reset
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			out_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign irq_out_o = out_reg;
	assign irq_oe_n_o = oe_n_reg;

endmodule

`default_nettype wire

// file: logic/expander_port_interrupt_logic.sv
// port data registers and interrupt-on-change logic of the expander
`timescale 1ns/1ps
`default_nettype none

module expander_port_interrupt_logic #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] port_pins_i,
	input wire expander_port_pkg::reg_req_type reg_req_i,
	input wire expander_port_pkg::pin_cfg_type pin_cfg_i,
	input wire expander_port_pkg::irq_cfg_type irq_cfg_i,
	output logic [WIDTH-1:0] reg_rdata_o,
	output logic [WIDTH-1:0] port_out_o,
	output logic [WIDTH-1:0] port_oe_n_o,
	output logic irq_pending_o,
	output logic irq_out_o,
	output logic irq_oe_n_o
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	// pins are trusted once the synchroniser has filled and settled
	localparam int SETTLE_CYCLES = expander_port_pkg::SYNC_STAGES + 2;
	localparam int SETTLE_BITS = $clog2(SETTLE_CYCLES + 1);
	logic [WIDTH-1:0] pin_level;
	logic [WIDTH-1:0] cond;
	logic [WIDTH-1:0] mismatch_value;
	logic [WIDTH-1:0] mismatch_ref;
	logic read_clear;
	logic latch_write;
	logic sel_flag;
	logic sel_capture;
	logic sel_port;
	logic sel_latch;
	logic accept;
	logic raise;
	logic settled;
	logic [WIDTH-1:0] ref_take;

	logic pending_reg;
	logic pending_next;
	logic [WIDTH-1:0] flag_reg;
	logic [WIDTH-1:0] flag_next;
	logic [WIDTH-1:0] capture_reg;
	logic [WIDTH-1:0] capture_next;
	logic [WIDTH-1:0] ref_reg;
	logic [WIDTH-1:0] ref_next;
	logic [SETTLE_BITS-1:0] settle_cnt_reg;
	logic [SETTLE_BITS-1:0] settle_cnt_next;
	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;
	logic [WIDTH-1:0] rdata_reg;
	logic [WIDTH-1:0] rdata_next;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// true when the access targets the given register
	function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
		hits = (addr == target);
	endfunction

	// ----------------------------------------------------------------
	// pin input path
	// ----------------------------------------------------------------
	pin_level_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.pins_i(port_pins_i),
		.level_o(pin_level)
	);

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	// one select per register, shared by the clear, write and read paths
	assign sel_flag = hits(reg_req_i.addr, expander_port_pkg::ADDR_INTERRUPT_FLAG);
	assign sel_capture = hits(reg_req_i.addr, expander_port_pkg::ADDR_INTERRUPT_CAPTURE);
	assign sel_port = hits(reg_req_i.addr, expander_port_pkg::ADDR_PORT_PIN_LEVELS);
	assign sel_latch = hits(reg_req_i.addr, expander_port_pkg::ADDR_OUTPUT_LATCH);
	// reads of capture or port clear the interrupt, writes never do
	assign read_clear = reg_req_i.rd && (sel_capture || sel_port);
	// port and latch writes both land in the latch
	assign latch_write = reg_req_i.wr && (sel_port || sel_latch);

	// ----------------------------------------------------------------
	// interrupt condition
	// ----------------------------------------------------------------
	// per-pin mismatch in both modes, then mode select and gating
	always_comb begin
		mismatch_value = pin_level ^ pin_cfg_i.compare_value;
		mismatch_ref = pin_level ^ ref_reg;
		cond = (pin_cfg_i.compare_mode_select & mismatch_value) |
			(~pin_cfg_i.compare_mode_select & mismatch_ref);
		cond = cond & pin_cfg_i.pin_irq_enable & pin_cfg_i.dir_input;
		if (!settled) begin
			cond = '0; // synchroniser still filling after reset
		end
	end

	// pins that move their reference when they raise
	assign ref_take = cond & ~pin_cfg_i.compare_mode_select;

	// ----------------------------------------------------------------
	// settle counter
	// ----------------------------------------------------------------
	// counts out the synchroniser fill so no false change follows reset
	always_comb begin
		settle_cnt_next = settle_cnt_reg;
		if (!settled) begin
			settle_cnt_next = settle_cnt_reg + SETTLE_BITS'(1);
		end
	end

	// settle count register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			settle_cnt_reg <= '0;
		end else begin
			settle_cnt_reg <= settle_cnt_next;
		end
	end

	// counter stops at its end value
	assign settled = (settle_cnt_reg == SETTLE_BITS'(SETTLE_CYCLES));

	// ----------------------------------------------------------------
	// interrupt state
	// ----------------------------------------------------------------
	// a new interrupt is taken when idle or in the clearing cycle, set wins
	assign accept = !pending_reg || read_clear;
	assign raise = accept && (|cond);

	// pending flag behind the interrupt pin
	always_comb begin
		pending_next = pending_reg;
		if (raise) begin
			pending_next = 1'b1;
		end else if (read_clear) begin
			pending_next = 1'b0;
		end
	end

	// pending register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pending_reg <= 1'b0;
		end else begin
			pending_reg <= pending_next;
		end
	end

	// flags gather while pending, restart from the raising pins
	always_comb begin
		flag_next = flag_reg;
		if (!accept) begin
			flag_next = flag_reg | cond;
		end else if (read_clear || raise) begin
			flag_next = cond;
		end
	end

	// flag register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_reg <= expander_port_pkg::RST_INTERRUPT_FLAG;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// capture frozen except on a raising edge
	always_comb begin
		capture_next = capture_reg;
		if (raise) begin
			capture_next = pin_level;
		end
	end

	// capture register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			capture_reg <= expander_port_pkg::RST_INTERRUPT_CAPTURE;
		end else begin
			capture_reg <= capture_next;
		end
	end

	// reference follows the pins until settled, then moves only for raising pins
	always_comb begin
		ref_next = ref_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (!settled) begin
				ref_next[i] = pin_level[i];
			end else if (raise && ref_take[i]) begin
				ref_next[i] = pin_level[i];
			end
		end
	end

	// reference register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ref_reg <= '0;
		end else begin
			ref_reg <= ref_next;
		end
	end

	// ----------------------------------------------------------------
	// output latch and read data
	// ----------------------------------------------------------------
	// latch takes port and latch writes
	always_comb begin
		latch_next = latch_reg;
		if (latch_write) begin
			latch_next = reg_req_i.wdata;
		end
	end

	// latch register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			latch_reg <= expander_port_pkg::RST_OUTPUT_LATCH;
		end else begin
			latch_reg <= latch_next;
		end
	end

	// registered read mux, data stands until the next read
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_req_i.rd) begin
			if (sel_flag) begin
				rdata_next = flag_reg;
			end else if (sel_capture) begin
				rdata_next = capture_reg;
			end else if (sel_port) begin
				rdata_next = pin_level;
			end else if (sel_latch) begin
				rdata_next = latch_reg;
			end else begin
				rdata_next = expander_port_pkg::UNMAPPED_READ_DATA;
			end
		end
	end

	// read data register
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= expander_port_pkg::RST_READ_DATA;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// data outputs straight from registers, enables from direction
	assign reg_rdata_o = rdata_reg;
	assign port_out_o = latch_reg;
	assign port_oe_n_o = pin_cfg_i.dir_input;
	assign irq_pending_o = pending_reg;

	// registered interrupt pin stage
	irq_pin_driver u_irq (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.active_i(pending_reg),
		.cfg_i(irq_cfg_i),
		.irq_out_o(irq_out_o),
		.irq_oe_n_o(irq_oe_n_o)
	);

endmodule

`default_nettype wire

// file: sim/host_bus_model.sv
// host side of the register request port
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input wire logic mclk_i,
	input wire logic [7:0] rdata_i,
	output var expander_port_pkg::reg_req_type req_o
);
	// ----
	// bus cycles
	// ----
	initial req_o = '0;
	// one-cycle request launched just after an edge, answer taken one edge later
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge mclk_i);
		#1 req_o = {~w, w, a, d};
		@(posedge mclk_i);
		#1 req_o = '0;
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

// file: sim/expander_port_interrupt_logic_properties.sv
// port and interrupt checker bound to the expander port logic
`timescale 1ns/1ps
`default_nettype none
module expander_port_checker #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] port_pins_i,
	input wire expander_port_pkg::reg_req_type reg_req_i,
	input wire expander_port_pkg::pin_cfg_type pin_cfg_i,
	input wire expander_port_pkg::irq_cfg_type irq_cfg_i,
	input wire logic [WIDTH-1:0] reg_rdata_o,
	input wire logic [WIDTH-1:0] port_out_o,
	input wire logic [WIDTH-1:0] port_oe_n_o,
	input wire logic irq_pending_o,
	input wire logic irq_out_o,
	input wire logic irq_oe_n_o
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic rd_clr;
	logic wr_lat;
	// clearing reads and latch writes
	assign rd_clr = reg_req_i.rd && (reg_req_i.addr == 8'h08 || reg_req_i.addr == 8'h09);
	assign wr_lat = reg_req_i.wr && (reg_req_i.addr == 8'h09 || reg_req_i.addr == 8'h0A);
	chk_latch_write: assert property (wr_lat |=> port_out_o == $past(reg_req_i.wdata))
		else $error("latch write lost");
	chk_latch_read: assert property (reg_req_i.rd && reg_req_i.addr == 8'h0A |=> reg_rdata_o == $past(port_out_o))
		else $error("latch read wrong");
	chk_pin_drive: assert property (port_oe_n_o == pin_cfg_i.dir_input)
		else $error("output enable wrong");
	chk_pend_hold: assert property (irq_pending_o && !rd_clr |=> irq_pending_o)
		else $error("pending dropped");
	chk_pend_cause: assert property ($rose(irq_pending_o) |-> $past(|(pin_cfg_i.pin_irq_enable & pin_cfg_i.dir_input)))
		else $error("pending without enabled input");
	chk_push_pull: assert property (!$past(rst_i) && !$past(irq_cfg_i.open_drain_select) |->
		!irq_oe_n_o && irq_out_o == ($past(irq_pending_o) ~^ $past(irq_cfg_i.irq_polarity)))
		else $error("push-pull level wrong");
	chk_open_drain: assert property (!$past(rst_i) && $past(irq_cfg_i.open_drain_select) |->
		!irq_out_o && irq_oe_n_o == !$past(irq_pending_o))
		else $error("open-drain drive wrong");
	chk_unmapped_zero: assert property (reg_req_i.rd && !(reg_req_i.addr inside {[8'h07:8'h0A]}) |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_stands: assert property (!reg_req_i.rd |=> $stable(reg_rdata_o))
		else $error("read data moved");
	cover property ($rose(irq_pending_o));
	cover property (rd_clr && irq_pending_o);
	cover property (irq_cfg_i.open_drain_select && irq_pending_o);
endmodule
bind expander_port_interrupt_logic expander_port_checker #(.WIDTH(WIDTH)) chk_u (.mclk_i, .rst_i, .port_pins_i,
	.reg_req_i, .pin_cfg_i, .irq_cfg_i, .reg_rdata_o, .port_out_o, .port_oe_n_o, .irq_pending_o, .irq_out_o,
	.irq_oe_n_o);
`default_nettype wire

// file: sim/expander_port_interrupt_logic_tb.sv
// self-checking bench for the expander port and interrupt logic
`timescale 1ns/1ps
`default_nettype none
module expander_port_interrupt_logic_tb;
	logic mclk = 1'h0;
	logic rst = 1'h1;
	logic [7:0] pins = 8'h00;
	logic [7:0] rdata, pout, poe_n, q;
	logic pend, iout, ioe_n;
	expander_port_pkg::reg_req_type req;
	expander_port_pkg::pin_cfg_type pcfg = '0;
	expander_port_pkg::irq_cfg_type icfg = '0;
	int bad_count = 0;
	int n_tests = 0;
	int exp_cap, exp_lat;
	expander_port_interrupt_logic #(.WIDTH(8)) dut_u (.mclk_i(mclk), .rst_i(rst), .port_pins_i(pins),
		.reg_req_i(req), .pin_cfg_i(pcfg), .irq_cfg_i(icfg), .reg_rdata_o(rdata), .port_out_o(pout),
		.port_oe_n_o(poe_n), .irq_pending_o(pend), .irq_out_o(iout), .irq_oe_n_o(ioe_n));
	host_bus_model host_u (.mclk_i(mclk), .rdata_i(rdata), .req_o(req));
	// ----
	// helpers
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host_u.access(1'h0, a, 8'h00, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.access(1'h1, a, d, q);
	endtask
	// new pin levels, then wait out the synchroniser
	task automatic pins_to(input logic [7:0] v);
		pins = v;
		repeat (6) @(posedge mclk);
		#1;
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----
	// clock, watchdog and tests
	// ----
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	initial begin
		#200000;
		bad_count++;
		report_and_stop;
	end
	initial begin
		void'($urandom(85));
		repeat (6) @(posedge mclk);
		#1 rst = 1'h0;
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h0B, 8'h00);
		for (int i = 0; i < 4; i++) begin
			exp_lat = $urandom & 8'hFF;
			wr(i[0] ? 8'h09 : 8'h0A, exp_lat[7:0]);
			chk(pout, exp_lat[7:0]);
			wr(8'h07, ~exp_lat[7:0]);
			wr(8'h08, ~exp_lat[7:0]);
			rd(8'h0A, exp_lat[7:0]);
			rd(8'h08, 8'h00);
		end
		pcfg.dir_input = 8'hF7;
		pcfg.pin_irq_enable = 8'h0B;
		@(posedge mclk);
		#1 chk(poe_n, 8'hF7);
		$display("test latch done");
		pins_to(8'h0C);
		chk(pend, 1'h0);
		exp_cap = ($urandom & 8'hF0) | 8'h0D;
		pins_to(exp_cap[7:0]);
		chk(pend, 1'h1);
		rd(8'h07, 8'h01);
		pins_to(exp_cap[7:0] | 8'h02);
		wr(8'h08, 8'h00);
		wr(8'h09, exp_lat[7:0]);
		chk(pend, 1'h1);
		rd(8'h07, 8'h03);
		rd(8'h08, exp_cap[7:0]);
		chk(pend, 1'h1);
		rd(8'h07, 8'h02);
		rd(8'h08, exp_cap[7:0] | 8'h02);
		chk(pend, 1'h0);
		rd(8'h09, pins);
		$display("test pin change done");
		pcfg.compare_mode_select = 8'h01;
		pcfg.compare_value = 8'h01;
		pins_to(pins);
		chk(pend, 1'h0);
		pcfg.compare_value = 8'h00;
		pins_to(pins);
		chk(pend, 1'h1);
		rd(8'h09, pins);
		chk(pend, 1'h1);
		for (int p = 1; p >= 0; p--) begin
			for (int k = 0; k < 4; k++) begin
				icfg = k[1:0];
				repeat (2) @(posedge mclk);
				#1 chk({iout, ioe_n}, k[1] ? {1'h0, !p[0]} : {k[0] ~^ p[0], 1'h0});
			end
			pins_to(pins & 8'hFE);
			rd(8'h09, pins);
			chk(pend, 1'h0);
		end
		$display("test compare done");
		rst = 1'h1;
		repeat (6) @(posedge mclk);
		#1 rst = 1'h0;
		pins_to(pins);
		chk(pend, 1'h0);
		chk(pout, 8'h00);
		chk({iout, ioe_n}, 8'h01);
		rd(8'h08, 8'h00);
		$display("test reset done");
		report_and_stop;
	end
endmodule
`default_nettype wire
